// *** design/cascadable_down_counter_timers.sv ***
// Two chainable 16-bit down-counting timers behind an AXI4-Lite slave
// Behaviour
// - Start flag set begins decrement per source tick
// - Timer mode underflow reloads and keeps counting
// - Every underflow sets that timer's request bit
// - Second timer can count first timer's underflows
// - Chained pair forms prescaled long-period timer
// - One-shot second timer triggered by lower underflow
// - Pulse one-shot drives timer1 output high
// - Pulse one-shot end: low, reload, stop, request
// - Plain one-shot end: reload, stop, request
// - One-shot trigger select plus start arms, not starts
// - Armed timer 0 starts on chosen input edge
// - Pulse output in timer mode drives shared pin
// - Pulse off releases pin, counting continues
// - Event mode, reload zero: each input edge of the chosen polarity interrupts
// - Both timers may count the undivided source
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
module cascadable_down_counter_timers #(
   parameter int DIV_SLOW = 8,
   parameter int DIV_SLOWER = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [timer_pkg::REG_ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [timer_pkg::REG_ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic timer0_input_pin,
   input wire logic port7_bit0_pin_in,
   output logic port7_bit0_pin_out,
   output logic port7_bit0_pin_oe,
   output logic timer1_output_pin_out,
   output logic timer1_output_pin_oe,
   output logic irq
);
   import timer_pkg::*;

   // Dividers are masked counters, so only powers of two up to the prescaler span work
   if (DIV_SLOW < 2 || DIV_SLOW > 256 || (DIV_SLOW & (DIV_SLOW - 1)) != 0 ||
       DIV_SLOWER < 2 || DIV_SLOWER > 256 || (DIV_SLOWER & (DIV_SLOWER - 1)) != 0) begin : g_bad
      $error("DIV_SLOW and DIV_SLOWER must be powers of two from 2 to 256");
   end

   localparam logic [PRE_W-1:0] MASK_SLOW = PRE_W'(DIV_SLOW - 1);
   localparam logic [PRE_W-1:0] MASK_SLOWER = PRE_W'(DIV_SLOWER - 1);

   state_t s;
   state_t next_s;
   logic [NUM_TIMERS-1:0] tick;
   logic [NUM_TIMERS-1:0] trig;
   logic [NUM_TIMERS-1:0] ev;
   logic [NUM_TIMERS-1:0] uf;
   logic pin_edge;

   function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old,
                                                input logic [31:0] d, input logic [3:0] be);
      logic [CNT_W-1:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = d[7:0];
      end
      if (be[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // Inputs are synchronous to aclk, so a one-flop history is enough for edges
   assign pin_edge = s.cfg[0].edge_rising ? (timer0_input_pin & ~s.pin_prev)
                                          : (~timer0_input_pin & s.pin_prev);

   for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_src
      always_comb begin
         unique case (s.cfg[i].src_div)
            2'h0: tick[i] = 1'b1;
            2'h1: tick[i] = (s.pre & MASK_SLOW) == MASK_SLOW;
            default: tick[i] = (s.pre & MASK_SLOWER) == MASK_SLOWER;
         endcase
      end
   end

   always_comb begin
      logic [NUM_TIMERS-1:0] clr;
      logic step;
      next_s = s;
      uf = '0;
      ev = '0;
      trig = '0;
      clr = '0;
      step = 1'b0;
      next_s.pre = s.pre + PRE_W'(1);
      next_s.pin_prev = timer0_input_pin;

      for (int i = 0; i < NUM_TIMERS; i++) begin
         // Lower timer takes the input pin, the upper one its neighbour's underflow
         trig[i] = (i == 0) ? pin_edge : uf[0];
         ev[i] = (i == 0) ? pin_edge : uf[0];
         if (!s.start[i]) begin
            next_s.tmr[i].st = T_IDLE;
            next_s.tmr[i].out = 1'b0;
         end else begin
            unique case (s.tmr[i].st)
               T_IDLE: begin
                  if (s.cfg[i].mode == MODE_ONESHOT && s.cfg[i].trig_sel) begin
                     next_s.tmr[i].st = T_ARMED;
                  end else begin
                     next_s.tmr[i].st = T_RUN;
                     next_s.tmr[i].count = s.reload[i];
                     next_s.tmr[i].out = s.cfg[i].pulse_en && s.cfg[i].mode == MODE_ONESHOT;
                  end
               end
               T_ARMED: begin
                  if (trig[i]) begin
                     next_s.tmr[i].st = T_RUN;
                     next_s.tmr[i].count = s.reload[i];
                     next_s.tmr[i].out = s.cfg[i].pulse_en;
                  end
               end
               T_RUN: begin
                  step = (s.cfg[i].mode == MODE_EVENT) ? ev[i] : tick[i];
                  if (step && s.cfg[i].mode == MODE_ONESHOT) begin
                     if (s.tmr[i].count <= CNT_W'(1)) begin
                        uf[i] = 1'b1;
                        next_s.tmr[i].count = s.reload[i];
                        next_s.tmr[i].out = 1'b0;
                        next_s.tmr[i].st = s.cfg[i].trig_sel ? T_ARMED : T_IDLE;
                        // A non-triggered one-shot runs once; software restarts it
                        next_s.start[i] = s.cfg[i].trig_sel;
                     end else begin
                        next_s.tmr[i].count = s.tmr[i].count - CNT_W'(1);
                     end
                  end else if (step) begin
                     if (s.tmr[i].count == '0) begin
                        uf[i] = 1'b1;
                        next_s.tmr[i].count = s.reload[i];
                        next_s.tmr[i].out = s.cfg[i].pulse_en & ~s.tmr[i].out;
                     end else begin
                        next_s.tmr[i].count = s.tmr[i].count - CNT_W'(1);
                     end
                  end
               end
               default: next_s.tmr[i].st = T_IDLE;
            endcase
         end
      end

      // Bus write channels are taken independently and joined before the response
      if (awvalid && s.awready) begin
         next_s.aw_full = 1'b1;
         next_s.aw_addr = awaddr;
      end
      if (wvalid && s.wready) begin
         next_s.w_full = 1'b1;
         next_s.w_data = wdata;
         next_s.w_strb = wstrb;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.aw_full && s.w_full && !s.bvalid) begin
         next_s.aw_full = 1'b0;
         next_s.w_full = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = RESP_OKAY;
         unique case (s.aw_addr)
            OFF_START: begin
               // Applied after the timer update, so a software set beats a done-clear
               if (s.w_strb[0]) begin
                  next_s.start = s.w_data[NUM_TIMERS-1:0];
               end
            end
            OFF_CFG0: begin
               if (s.w_strb[0]) begin
                  next_s.cfg[0] = cfg_t'(s.w_data[7:0] & 8'h7F);
               end
            end
            OFF_CFG1: begin
               if (s.w_strb[0]) begin
                  next_s.cfg[1] = cfg_t'(s.w_data[7:0] & 8'h7F);
               end
            end
            OFF_RELOAD0: next_s.reload[0] = merge16(s.reload[0], s.w_data, s.w_strb);
            OFF_RELOAD1: next_s.reload[1] = merge16(s.reload[1], s.w_data, s.w_strb);
            OFF_STATUS: begin
               if (s.w_strb[0]) begin
                  clr = s.w_data[NUM_TIMERS-1:0];
               end
            end
            OFF_MASK: begin
               if (s.w_strb[0]) begin
                  next_s.irq_mask = s.w_data[NUM_TIMERS-1:0];
               end
            end
            OFF_COUNT0, OFF_COUNT1: next_s.bresp = RESP_OKAY;
            default: next_s.bresp = RESP_SLVERR;
         endcase
      end
      next_s.awready = ~next_s.aw_full;
      next_s.wready = ~next_s.w_full;

      // Set wins over a write-one-to-clear landing in the same cycle
      next_s.status = (s.status & ~clr) | uf;
      next_s.irq = |(next_s.status & next_s.irq_mask);

      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      if (arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = RESP_OKAY;
         next_s.rdata = '0;
         unique case (araddr)
            OFF_START: begin
               next_s.rdata[NUM_TIMERS-1:0] = s.start;
               next_s.rdata[PIN_LEVEL_BIT] = port7_bit0_pin_in;
            end
            OFF_CFG0: next_s.rdata[7:0] = s.cfg[0];
            OFF_CFG1: next_s.rdata[7:0] = s.cfg[1];
            OFF_RELOAD0: next_s.rdata[CNT_W-1:0] = s.reload[0];
            OFF_RELOAD1: next_s.rdata[CNT_W-1:0] = s.reload[1];
            OFF_COUNT0: next_s.rdata[CNT_W+1:0] = {s.tmr[0].st, s.tmr[0].count};
            OFF_COUNT1: next_s.rdata[CNT_W+1:0] = {s.tmr[1].st, s.tmr[1].count};
            OFF_STATUS: next_s.rdata[NUM_TIMERS-1:0] = s.status;
            OFF_MASK: next_s.rdata[NUM_TIMERS-1:0] = s.irq_mask;
            default: next_s.rresp = RESP_SLVERR;
         endcase
      end
      next_s.arready = ~next_s.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.cfg <= {NUM_TIMERS{CFG_RESET}};
         s.reload <= {NUM_TIMERS{RELOAD_RESET}};
         s.awready <= 1'b1;
         s.wready <= 1'b1;
         s.arready <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign irq = s.irq;
   assign port7_bit0_pin_out = s.tmr[0].out;
   assign port7_bit0_pin_oe = s.cfg[0].pulse_en;
   assign timer1_output_pin_out = s.tmr[1].out;
   assign timer1_output_pin_oe = s.cfg[1].pulse_en;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_start_loads: assert property (s.start[0] && s.tmr[0].st == T_IDLE &&
      !(s.cfg[0].mode == MODE_ONESHOT && s.cfg[0].trig_sel)
      |=> s.tmr[0].st == T_RUN && s.tmr[0].count == $past(s.reload[0]))
      else $error("start did not load the reload value");
   a_count_decrement: assert property (s.start[0] && s.tmr[0].st == T_RUN &&
      s.cfg[0].mode == MODE_TIMER && tick[0] && s.tmr[0].count != '0
      |=> s.tmr[0].count == $past(s.tmr[0].count) - CNT_W'(1))
      else $error("running timer did not decrement");
   a_timer_reload: assert property (s.start[0] && s.tmr[0].st == T_RUN &&
      s.cfg[0].mode == MODE_TIMER && tick[0] && s.tmr[0].count == '0
      |=> s.tmr[0].st == T_RUN && s.tmr[0].count == $past(s.reload[0]))
      else $error("timer mode underflow did not reload");
   // A status clear lands at the edge that raises bvalid, so that cycle may show it gone
   a_underflow_request: assert property (uf[1] |=> s.status[1] ##1 (s.status[1] ||
      (s.aw_addr == OFF_STATUS && s.bvalid)))
      else $error("underflow lost its request bit");
   a_chain_count: assert property (s.start[1] && s.tmr[1].st == T_RUN &&
      s.cfg[1].mode == MODE_EVENT && !uf[0] |=> s.tmr[1].count == $past(s.tmr[1].count))
      else $error("chained timer moved without a lower underflow");
   a_oneshot_trigger: assert property (s.start[1] && s.tmr[1].st == T_ARMED && uf[0]
      |=> s.tmr[1].st == T_RUN && s.tmr[1].out == $past(s.cfg[1].pulse_en))
      else $error("lower underflow did not start the one-shot");
   a_oneshot_end: assert property (s.start[1] && s.tmr[1].st == T_RUN &&
      s.cfg[1].mode == MODE_ONESHOT && tick[1] && s.tmr[1].count <= CNT_W'(1)
      |=> !timer1_output_pin_out && s.tmr[1].st != T_RUN && s.status[1])
      else $error("one-shot end sequence wrong");
   a_armed_waits: assert property (s.tmr[0].st == T_ARMED && !pin_edge &&
      s.start[0] |=> s.tmr[0].st == T_ARMED)
      else $error("armed timer started without a trigger");
   a_edge_start: assert property (s.start[0] && s.tmr[0].st == T_ARMED && pin_edge
      |=> s.tmr[0].st == T_RUN)
      else $error("input edge did not start the armed timer");
   a_event_interrupt: assert property (s.start[0] && s.tmr[0].st == T_RUN &&
      s.cfg[0].mode == MODE_EVENT && s.reload[0] == '0 && s.tmr[0].count == '0 && pin_edge
      |=> s.status[0])
      else $error("event edge with zero reload did not interrupt");
   // Request and interrupt are registered at the same edge, so no lag is allowed
   a_irq_level: assert property (s.status[0] && s.irq_mask[0] |-> irq)
      else $error("unmasked request did not raise the interrupt");

   // Timer 0 carries most checks; both timers share the same per-timer logic
   a_plain_oneshot_end: assert property (s.start[0] && s.tmr[0].st == T_RUN &&
      s.cfg[0].mode == MODE_ONESHOT && !s.cfg[0].pulse_en && tick[0] &&
      s.tmr[0].count <= CNT_W'(1)
      |=> s.tmr[0].count == $past(s.reload[0]) && s.tmr[0].st != T_RUN && s.status[0])
      else $error("plain one-shot end sequence wrong");
   a_pulse_start: assert property (s.start[1] && s.tmr[1].st == T_ARMED && uf[0] &&
      s.cfg[1].pulse_en |=> timer1_output_pin_out)
      else $error("one-shot pulse did not rise at its start");
   a_release_counts: assert property (s.start[0] && s.tmr[0].st == T_RUN &&
      s.cfg[0].mode == MODE_TIMER && !port7_bit0_pin_oe |=> s.tmr[0].st == T_RUN)
      else $error("released pin stopped the timer");
   a_slow_tick: assert property (s.start[0] && s.tmr[0].st == T_RUN &&
      s.cfg[0].mode == MODE_TIMER && s.cfg[0].src_div == 2'h1 &&
      (s.pre & MASK_SLOW) != MASK_SLOW |=> s.tmr[0].count == $past(s.tmr[0].count))
      else $error("divided source stepped between its ticks");
   a_pulse_train: assert property (s.start[0] && s.tmr[0].st == T_RUN &&
      s.cfg[0].mode == MODE_TIMER && s.cfg[0].pulse_en && tick[0] && s.tmr[0].count == '0
      |=> port7_bit0_pin_out != $past(port7_bit0_pin_out))
      else $error("underflow did not toggle the pulse output");
   a_start_arms: assert property (s.start[0] && s.tmr[0].st == T_IDLE &&
      s.cfg[0].mode == MODE_ONESHOT && s.cfg[0].trig_sel |=> s.tmr[0].st == T_ARMED)
      else $error("triggered one-shot started without waiting");

   c_chain_underflow: cover property (s.cfg[1].mode == MODE_EVENT && uf[1]);
   c_oneshot_done: cover property (s.tmr[1].st == T_RUN ##[1:1000] uf[1]);
   c_event_pin: cover property (s.cfg[0].mode == MODE_EVENT && uf[0]);
   c_pin_release: cover property (port7_bit0_pin_oe ##1 !port7_bit0_pin_oe);
   c_slow_source: cover property (s.cfg[0].src_div != 2'h0 && uf[0]);
endmodule

// *** common/timer_pkg.sv ***
// Package for the cascadable down-counter timer pair: map, fields, types, state
package timer_pkg;

   localparam int CNT_W = 16;
   localparam int NUM_TIMERS = 2;
   localparam int REG_ADDR_W = 8;
   localparam int PRE_W = 8;

   localparam logic [7:0] OFF_START = 8'h00;
   localparam logic [7:0] OFF_CFG0 = 8'h04;
   localparam logic [7:0] OFF_CFG1 = 8'h08;
   localparam logic [7:0] OFF_RELOAD0 = 8'h0C;
   localparam logic [7:0] OFF_RELOAD1 = 8'h10;
   localparam logic [7:0] OFF_COUNT0 = 8'h14;
   localparam logic [7:0] OFF_COUNT1 = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1C;
   localparam logic [7:0] OFF_MASK = 8'h20;

   localparam int PIN_LEVEL_BIT = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [CNT_W-1:0] RELOAD_RESET = 16'hFFFF;

   typedef enum logic [1:0] {
      MODE_TIMER = 2'b00,
      MODE_EVENT = 2'b01,
      MODE_ONESHOT = 2'b10,
      MODE_RSVD = 2'b11
   } mode_t;

   typedef enum logic [1:0] {
      T_IDLE = 2'b00,
      T_ARMED = 2'b01,
      T_RUN = 2'b10
   } tstate_t;

   // Source select: 0 undivided, 1 slow divider, 2 and 3 slower divider
   typedef struct packed {
      logic reserved;
      logic [1:0] src_div;
      logic edge_rising;
      logic trig_sel;
      logic pulse_en;
      mode_t mode;
   } cfg_t;

   localparam cfg_t CFG_RESET = '{reserved: 1'b0, src_div: 2'h0, edge_rising: 1'b0,
      trig_sel: 1'b0, pulse_en: 1'b0, mode: MODE_TIMER};

   typedef struct packed {
      tstate_t st;
      logic out;
      logic [CNT_W-1:0] count;
   } tmr_t;

   typedef struct packed {
      logic [NUM_TIMERS-1:0] start;
      logic [NUM_TIMERS-1:0] status;
      logic [NUM_TIMERS-1:0] irq_mask;
      cfg_t [NUM_TIMERS-1:0] cfg;
      logic [NUM_TIMERS-1:0][CNT_W-1:0] reload;
      tmr_t [NUM_TIMERS-1:0] tmr;
      logic [PRE_W-1:0] pre;
      logic pin_prev;
      logic aw_full;
      logic [REG_ADDR_W-1:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic irq;
   } state_t;

endpackage

// *** verification/cascadable_down_counter_timers_tb.sv ***
// Self-checking bench for the cascadable down-counter timer pair
module cascadable_down_counter_timers_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import timer_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [REG_ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = '0;
   logic pin = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic p7_out, p7_oe, t1_out, t1_oe, p7_level;
   logic [1:0] bresp, rresp, wr_resp, rd_resp;
   logic [31:0] rdata, rv;
   logic ok;
   int err_total = 0, tests_run = 0, cyc = 0, t0, t1;
   // Shared pin follows the driver when enabled, pulled up when released
   assign p7_level = p7_oe ? p7_out : 1'b1;
   cascadable_down_counter_timers #(.DIV_SLOW(8), .DIV_SLOWER(32))
   cascadable_down_counter_timers_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .timer0_input_pin(pin),
      .port7_bit0_pin_in(p7_level), .port7_bit0_pin_out(p7_out), .port7_bit0_pin_oe(p7_oe),
      .timer1_output_pin_out(t1_out), .timer1_output_pin_oe(t1_oe), .irq(irq));
   always #2 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Open-ended waits: only the watchdog ends a stuck handshake
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hF;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      wr_resp = bresp;
      bready <= 1'b0;
      // Response comes one cycle after both channels are taken
      check(32'(n), 32'd3);
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rv = rdata;
      rd_resp = rresp;
      rready <= 1'b0;
      check(32'(n), 32'd2);
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return irq;
         1: return t1_out;
         default: return p7_out;
      endcase
   endfunction

   task automatic wait_for(input int sel, input logic lvl, input int lim);
      int n;
      ok = 1'b0;
      for (n = 0; n < lim && !ok; n++) begin
         @(posedge aclk);
         if (pick(sel) === lvl) ok = 1'b1;
      end
   endtask

   task t_regs;
      check({awready, wready, arready, irq, p7_oe, t1_oe}, 32'h38);
      rd(OFF_CFG0); check(rv, 32'h0);
      rd(OFF_RELOAD1); check(rv, 32'h0000FFFF);
      rd(OFF_STATUS); check(rv, 32'h0);
      rd(8'h40); check({rd_resp, rv[3:0]}, {RESP_SLVERR, 4'h0});
      wr(8'h40, 32'h1); check(wr_resp, RESP_SLVERR);
      wr(OFF_COUNT0, 32'h1234); check(wr_resp, RESP_OKAY);
      rd(OFF_COUNT0); check(rv, 32'h0);
      $display("registers test done");
   endtask

   task t_timer;
      wr(OFF_RELOAD0, 32'h3); wr(OFF_CFG0, 32'h4);
      check(p7_oe, 1'b1);
      wr(OFF_START, 32'h1);
      wait_for(2, ~p7_out, 50); t0 = cyc;
      wait_for(2, ~p7_out, 50); check(32'(cyc - t0), 32'd4);
      t0 = cyc;
      wait_for(2, ~p7_out, 50); check(32'(cyc - t0), 32'd4);
      rd(OFF_STATUS); check(rv[0], 1'b1);
      check(irq, 1'b0);
      wr(OFF_MASK, 32'h1); repeat (2) @(posedge aclk);
      check(irq, 1'b1);
      wr(OFF_CFG0, 32'h0); repeat (2) @(posedge aclk);
      check(p7_oe, 1'b0);
      rd(OFF_START); check(rv[PIN_LEVEL_BIT], 1'b1);
      rd(OFF_COUNT0); check(rv[17:16], 2'h2);
      wr(OFF_START, 32'h0); wr(OFF_STATUS, 32'h1); repeat (2) @(posedge aclk);
      rd(OFF_STATUS); check(rv, 32'h0);
      check(irq, 1'b0);
      $display("timer test done");
   endtask

   task t_slow;
      wr(OFF_RELOAD0, 32'h1);
      wr(OFF_CFG0, 32'h24);
      wr(OFF_START, 32'h1);
      wait_for(2, ~p7_out, 200);
      t0 = cyc;
      // Two ticks of the divide-by-8 source per underflow
      wait_for(2, ~p7_out, 200);
      check(32'(cyc - t0), 32'd16);
      wr(OFF_CFG0, 32'h44);
      wait_for(2, ~p7_out, 200);
      t0 = cyc;
      wait_for(2, ~p7_out, 200);
      check(32'(cyc - t0), 32'd64);
      wr(OFF_START, 32'h0);
      wr(OFF_CFG0, 32'h0);
      wr(OFF_STATUS, 32'h1);
      $display("slow source test done");
   endtask

   task t_cascade;
      wr(OFF_RELOAD0, 32'h3); wr(OFF_RELOAD1, 32'h1); wr(OFF_CFG1, 32'h1);
      wr(OFF_MASK, 32'h2); wr(OFF_START, 32'h3);
      wait_for(0, 1'b1, 100); t0 = cyc;
      wr(OFF_STATUS, 32'h2); repeat (2) @(posedge aclk);
      // Four clocks per timer0 period, two timer0 underflows per timer1 period
      wait_for(0, 1'b1, 100); check(32'(cyc - t0), 32'd8);
      rd(OFF_STATUS); check(rv[1:0], 2'h3);
      wr(OFF_START, 32'h0); wr(OFF_STATUS, 32'h3); wr(OFF_MASK, 32'h0);
      $display("cascade test done");
   endtask

   task t_oneshot;
      wr(OFF_RELOAD0, 32'h5); wr(OFF_RELOAD1, 32'h4);
      wr(OFF_CFG0, 32'h0A); wr(OFF_CFG1, 32'h0E); wr(OFF_START, 32'h3);
      rd(OFF_COUNT0); check(rv[17:16], 2'h1);
      rd(OFF_COUNT1); check(rv[17:16], 2'h1);
      @(posedge aclk) pin <= 1'b1;
      repeat (10) @(posedge aclk);
      rd(OFF_COUNT0); check(rv[17:16], 2'h1);
      check({t1_oe, t1_out}, 2'b10);
      @(posedge aclk) pin <= 1'b0;
      t0 = cyc;
      wait_for(1, 1'b1, 50); t1 = cyc;
      check(ok, 1'b1);
      check(32'(t1 - t0 >= 5 && t1 - t0 <= 8), 32'h1);
      wait_for(1, 1'b0, 50); check(32'(cyc - t1), 32'd4);
      repeat (2) @(posedge aclk);
      rd(OFF_STATUS); check(rv[1:0], 2'h3);
      rd(OFF_COUNT0); check(rv[17:0], 18'h10005);
      rd(OFF_COUNT1); check(rv[17:0], 18'h10004);
      wr(OFF_START, 32'h0); wr(OFF_STATUS, 32'h3); wr(OFF_CFG1, 32'h0);
      $display("one-shot test done");
   endtask

   task t_event;
      int i;
      @(posedge aclk) pin <= 1'b1;
      wr(OFF_CFG0, 32'h1); wr(OFF_RELOAD0, 32'h0); wr(OFF_MASK, 32'h1); wr(OFF_START, 32'h1);
      for (i = 0; i < 3; i++) begin
         @(posedge aclk) pin <= 1'b0;
         wait_for(0, 1'b1, 10); check(ok, 1'b1);
         wr(OFF_STATUS, 32'h1);
         @(posedge aclk) pin <= 1'b1;
         repeat (4) @(posedge aclk);
         check(irq, 1'b0);
      end
      // Rising edge chosen: a falling edge must now pass unseen
      wr(OFF_CFG0, 32'h11);
      @(posedge aclk) pin <= 1'b0;
      repeat (4) @(posedge aclk);
      check(irq, 1'b0);
      @(posedge aclk) pin <= 1'b1;
      wait_for(0, 1'b1, 10);
      check(ok, 1'b1);
      $display("event test done");
   endtask

   initial begin
      #100000;
      err_total++;
      tally_and_finish;
   end

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_timer;
      t_slow;
      t_cascade;
      t_oneshot;
      t_event;
      tally_and_finish;
   end
endmodule
